// file: ext_mem_pkg.sv
// Shared constants and carriers for the external data memory strobe engine.
// Assumes a single system clock and registers written through dedicated strobes.
package ext_mem_pkg;

  // ==========================================================================
  // Timing control register layout
  localparam int          SETUP_MSB        = 7;
  localparam int          SETUP_LSB        = 6;
  localparam int          WIDTH_MSB        = 5;
  localparam int          WIDTH_LSB        = 2;
  localparam int          HOLD_MSB         = 1;
  localparam int          HOLD_LSB         = 0;
  localparam logic [7:0]  TIMING_RESET     = 8'hff;

  // ==========================================================================
  // Configuration register layout
  localparam int          MUX_SELECT_BIT   = 4;
  localparam int          MODE_MSB         = 3;
  localparam int          MODE_LSB         = 2;
  localparam int          LATCH_MSB        = 1;
  localparam int          LATCH_LSB        = 0;
  localparam logic [4:0]  CONFIG_RESET     = 5'h00;
  localparam logic [7:0]  PAGE_RESET       = 8'h00;
  localparam logic [1:0]  MODE_INTERNAL    = 2'h0;
  localparam logic [1:0]  MODE_BANK_SELECT = 2'h2;

  // ==========================================================================
  // Fixed cycle counts
  localparam int          FIXED_CYCLES     = 4;
  localparam logic [4:0]  TAIL_LOAD        = 5'h02;
  localparam logic [4:0]  READ_SAMPLE_CNT  = 5'h01;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_ALE_HI = 3'h3,
    ST_ALE_LO = 3'h2,
    ST_SETUP  = 3'h6,
    ST_STROBE = 3'h7,
    ST_HOLD   = 3'h5,
    ST_TAIL   = 3'h4
  } phase_t;

  typedef struct packed {
    logic       write;
    logic       wide;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xfer_req_t;

  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       ale;
    logic [7:0] addr_hi;
    logic       addr_hi_oe;
    logic [7:0] addr_lo;
    logic       addr_lo_oe;
    logic [7:0] data_out;
    logic       data_oe;
  } mem_pins_t;

endpackage

// file: phase_timer.sv
// Down counter that measures the length of one bus phase.
// Assumes load is asserted on the cycle a new phase is entered.
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              last,
  output logic [W-1:0]      count
);

  logic [W-1:0] cnt_q;

  // ==========================================================================
  // Counter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign last  = (cnt_q == '0);
  assign count = cnt_q;

endmodule
`default_nettype wire

// file: ext_mem_strobe.sv
// External data memory strobe engine: sequences one off-chip transfer.
// Assumes the core holds the request stable while req_valid is high and idle.
// Pin inputs are asynchronous and are synchronised before use.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_strobe (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  req_valid,
  input  wire ext_mem_pkg::xfer_req_t req,
  output logic                       busy,
  output logic                       done,
  output logic [7:0]                 rdata,
  input  wire logic                  timing_we,
  input  wire logic [7:0]            timing_wdata,
  input  wire logic                  config_we,
  input  wire logic [4:0]            config_wdata,
  input  wire logic                  page_we,
  input  wire logic [7:0]            page_wdata,
  output logic [7:0]                 ext_mem_timing_control,
  output logic [4:0]                 ext_mem_config,
  output logic [7:0]                 page_register,
  input  wire logic [7:0]            data_in,
  output ext_mem_pkg::mem_pins_t     pins
);
  import ext_mem_pkg::*;

  phase_t     state_q, state_d;
  xfer_req_t  req_q;
  logic [7:0] tm_q, timing_q, page_q, data_s1_q, data_s2_q, rdata_q;
  logic [4:0] cf_q, config_q, tload;
  logic       take, tlast, busy_q, done_q, mux;
  logic [1:0] rd_cap_q;
  mem_pins_t  pins_q, pins_d;

  function automatic logic [1:0] setup_of(input logic [7:0] t);
    return t[SETUP_MSB:SETUP_LSB];
  endfunction
  function automatic logic [3:0] width_of(input logic [7:0] t);
    return t[WIDTH_MSB:WIDTH_LSB];
  endfunction
  function automatic logic [1:0] hold_of(input logic [7:0] t);
    return t[HOLD_MSB:HOLD_LSB];
  endfunction

  // ==========================================================================
  // Software registers
  // max setup and hold
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timing_q <= TIMING_RESET;
    end else if (timing_we) begin
      timing_q <= timing_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      config_q <= CONFIG_RESET;
    end else if (config_we) begin
      config_q <= config_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      page_q <= PAGE_RESET;
    end else if (page_we) begin
      page_q <= page_wdata;
    end
  end

  // ==========================================================================
  // Request capture; timing and config settings frozen for the whole transfer, page register used live
  assign take = (state_q == ST_IDLE) && req_valid;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_q <= '0;
      tm_q  <= TIMING_RESET;
      cf_q  <= CONFIG_RESET;
    end else if (take) begin
      req_q <= req;
      tm_q  <= timing_q;
      cf_q  <= config_q;
    end
  end

  assign mux = ~cf_q[MUX_SELECT_BIT];

  // ==========================================================================
  // Phase sequencing
  always_comb begin
    state_d = state_q;
    if (tlast) begin
      unique case (state_q)
        ST_IDLE: begin
          if (take && config_q[MODE_MSB:MODE_LSB] != MODE_INTERNAL) begin
            state_d = ST_START;
          end
        end
        ST_START:  state_d = mux ? ST_ALE_HI
                           : (setup_of(tm_q) != 2'h0 ? ST_SETUP : ST_STROBE);
        ST_ALE_HI: state_d = ST_ALE_LO;
        ST_ALE_LO: state_d = setup_of(tm_q) != 2'h0 ? ST_SETUP : ST_STROBE;
        ST_SETUP:  state_d = ST_STROBE;
        ST_STROBE: state_d = hold_of(tm_q) != 2'h0 ? ST_HOLD : ST_TAIL;
        ST_HOLD:   state_d = ST_TAIL;
        ST_TAIL:   state_d = ST_IDLE;
      endcase
    end
  end

  // setup length; width plus one; hold length; fixed tail
  always_comb begin
    unique case (state_d)
      ST_ALE_HI, ST_ALE_LO: tload = {3'h0, cf_q[LATCH_MSB:LATCH_LSB]};
      ST_SETUP:             tload = {3'h0, setup_of(tm_q) - 2'h1};
      ST_STROBE:            tload = {1'b0, width_of(tm_q)};
      ST_HOLD:              tload = {3'h0, hold_of(tm_q) - 2'h1};
      ST_TAIL:              tload = TAIL_LOAD;
      default:              tload = 5'h00;
    endcase
  end

  phase_timer #(.W(5)) u_timer (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .load     (state_d != state_q),
    .load_val (tload),
    .last     (tlast),
    .count    ()
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Pin drive, registered from the next phase
  always_comb begin
    logic addr_phase;
    logic data_phase;
    addr_phase = state_d inside {ST_SETUP, ST_STROBE, ST_HOLD};
    data_phase = addr_phase && req_q.write;
    pins_d = '0;
    pins_d.rd_n = 1'b1;
    pins_d.wr_n = 1'b1;
    if (state_d == ST_STROBE) begin
      pins_d.rd_n = req_q.write;
      pins_d.wr_n = ~req_q.write;
    end
    pins_d.ale = (state_d == ST_ALE_HI);
    if (addr_phase || state_d inside {ST_ALE_HI, ST_ALE_LO}) begin
      if (req_q.wide) begin
        pins_d.addr_hi    = req_q.addr[15:8];
        pins_d.addr_hi_oe = 1'b1;
      end else if (cf_q[MODE_MSB:MODE_LSB] == MODE_BANK_SELECT) begin
        pins_d.addr_hi    = page_q;
        pins_d.addr_hi_oe = 1'b1;
      end
    end
    if (!mux && addr_phase) begin
      pins_d.addr_lo    = req_q.addr[7:0];
      pins_d.addr_lo_oe = 1'b1;
    end
    // low address shares the data pins
    if (mux && state_d inside {ST_ALE_HI, ST_ALE_LO}) begin
      pins_d.data_out = req_q.addr[7:0];
      pins_d.data_oe  = 1'b1;
    end
    if (data_phase) begin
      pins_d.data_out = req_q.wdata;
      pins_d.data_oe  = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pins_q <= '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      pins_q <= pins_d;
    end
  end

  // ==========================================================================
  // Read data capture and completion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
    end else begin
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
    end
  end

  // strobe-end sample, delayed past both sync stages
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_cap_q <= 2'h0;
    end else begin
      rd_cap_q <= {rd_cap_q[0], state_q == ST_STROBE && state_d != ST_STROBE && !req_q.write};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (rd_cap_q[1]) begin
      rdata_q <= data_s2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_TAIL && state_d == ST_IDLE)
             || (take && config_q[MODE_MSB:MODE_LSB] == MODE_INTERNAL);
      busy_q <= (state_d != ST_IDLE);
    end
  end

  assign busy                   = busy_q;
  assign done                   = done_q;
  assign rdata                  = rdata_q;
  assign ext_mem_timing_control = timing_q;
  assign ext_mem_config         = config_q;
  assign page_register          = page_q;
  assign pins                   = pins_q;

  // ==========================================================================
  // Checks
  logic [5:0] low_len_q, txn_len_q, phase_len_q;
  phase_t     prev_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_len_q   <= 6'h00;
      txn_len_q   <= 6'h00;
      phase_len_q <= 6'h00;
      prev_q      <= ST_IDLE;
    end else begin
      low_len_q   <= (!pins_q.rd_n || !pins_q.wr_n) ? low_len_q + 6'h01 : 6'h00;
      txn_len_q   <= (state_q != ST_IDLE) ? txn_len_q + 6'h01 : 6'h00;
      phase_len_q <= (state_q == prev_q) ? phase_len_q + 6'h01 : 6'h01;
      prev_q      <= state_q;
    end
  end

  a_strobe_width: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(pins_q.rd_n & pins_q.wr_n) |-> low_len_q == {2'h0, width_of(tm_q)} + 6'h01)
    else $error("strobe width wrong");
  a_setup_len: assert property (@(posedge mclk) disable iff (sys_rst)
    (prev_q == ST_SETUP && state_q == ST_STROBE) |-> phase_len_q == {4'h0, setup_of(tm_q)})
    else $error("setup length wrong");
  a_hold_len: assert property (@(posedge mclk) disable iff (sys_rst)
    (prev_q == ST_HOLD && state_q == ST_TAIL) |-> phase_len_q == {4'h0, hold_of(tm_q)})
    else $error("hold length wrong");
  a_ale_len: assert property (@(posedge mclk) disable iff (sys_rst)
    (prev_q == ST_ALE_HI && state_q == ST_ALE_LO)
      |-> phase_len_q == {4'h0, cf_q[LATCH_MSB:LATCH_LSB]} + 6'h01)
    else $error("latch pulse wrong");
  a_txn_total: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(done) && cf_q[MODE_MSB:MODE_LSB] != MODE_INTERNAL |-> txn_len_q ==
      {4'h0, setup_of(tm_q)} + {2'h0, width_of(tm_q)} + {4'h0, hold_of(tm_q)} + 6'h05
      + (mux ? {3'h0, cf_q[LATCH_MSB:LATCH_LSB], 1'b0} + 6'h02 : 6'h00))
    else $error("transfer length wrong");
  a_reset_max: assert property (@(posedge mclk)
    $past(sys_rst) && !timing_we |-> setup_of(timing_q) == 2'h3 && hold_of(timing_q) == 2'h3
      || !$past(sys_rst))
    else $error("reset timing not max");
  a_mux_pins: assert property (@(posedge mclk) disable iff (sys_rst)
    !(pins_q.rd_n && pins_q.wr_n) |-> pins_q.addr_lo_oe == !mux)
    else $error("address pin use wrong");
  a_bank_hi: assert property (@(posedge mclk) disable iff (sys_rst)
    !pins_q.wr_n && !req_q.wide && cf_q[MODE_MSB:MODE_LSB] == MODE_BANK_SELECT
      |-> pins_q.addr_hi_oe && pins_q.addr_hi == page_q)
    else $error("bank byte wrong");
  a_nobank_hi: assert property (@(posedge mclk) disable iff (sys_rst)
    !(pins_q.rd_n && pins_q.wr_n) && !req_q.wide
      && cf_q[MODE_MSB:MODE_LSB] != MODE_BANK_SELECT |-> !pins_q.addr_hi_oe)
    else $error("upper byte driven");
  a_write_data: assert property (@(posedge mclk) disable iff (sys_rst)
    !pins_q.wr_n |-> pins_q.data_oe && pins_q.data_out == req_q.wdata)
    else $error("write data missing");
  a_read_sample: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(pins_q.rd_n) |-> ##2 rdata == $past(data_in, 3))
    else $error("read sample wrong");

  c_mux_read:   cover property (@(posedge mclk) $rose(pins_q.rd_n) && mux);
  c_plain_wr:   cover property (@(posedge mclk) $rose(pins_q.wr_n) && !mux);
  c_bank_read:  cover property (@(posedge mclk) !pins_q.rd_n && pins_q.addr_hi_oe && !req_q.wide);
  c_internal:   cover property (@(posedge mclk) done && !pins_q.ale && txn_len_q == 6'h00);

endmodule
`default_nettype wire

// file: sram_model.sv
// Behavioural asynchronous SRAM with the low-address latch of multiplexed mode.
// Assumes registered pins from the strobe engine; it needs no clock.
`timescale 1ns/1ps
`default_nettype none
module sram_model
  import ext_mem_pkg::*;
#(
  parameter logic [7:0] PORT_HI = 8'h3c
) (
  input  wire ext_mem_pkg::mem_pins_t pins,
  output logic [7:0]                  data_in
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_lo;
  logic [15:0] addr;

  // ==========================================================================
  // Address latch, transparent while ale is high
  always_latch begin
    if (pins.ale && pins.data_oe) begin
      lat_lo = pins.data_out;
    end
  end

  // undriven upper byte comes from port latches
  assign addr = {pins.addr_hi_oe ? pins.addr_hi : PORT_HI,
                 pins.addr_lo_oe ? pins.addr_lo : lat_lo};

  // ==========================================================================
  // Array write while the write strobe is low
  always @* begin
    if (!pins.wr_n && pins.data_oe) begin
      mem[addr] = pins.data_out;
    end
  end

  // data valid only while read strobe low; weak pull-up otherwise
  always @* begin
    if (!pins.rd_n) begin
      data_in = mem[addr];
    end else begin
      data_in = 8'hff;
    end
  end
endmodule
`default_nettype wire

// file: ext_mem_strobe_tb.sv
// Self-checking bench for the external memory strobe engine.
// Assumes the sram_model partner and the ext_mem_pkg carriers.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_strobe_tb;
  import ext_mem_pkg::*;
  typedef struct packed {
    logic [4:0]  cfg;
    logic [7:0]  tc;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wd;
  } row_t;
  localparam logic [7:0] PAGE = 8'h5a;
  logic       mclk, sys_rst, req_valid, busy, done, act, hi_oe_s, mux;
  logic       timing_we, config_we, page_we;
  logic [7:0] rdata, timing_wdata, page_wdata, tc_q, pg_q, data_in, hi_s;
  logic [4:0] config_wdata, cfg_q;
  logic [15:0] adr_s;
  xfer_req_t  req;
  mem_pins_t  pins;
  row_t       r;
  int         failures, total_checks, n_tot, n_stb, n_set, n_hld, n_ale, nexp;
  row_t       rows [8] = '{'{5'h14, 8'h00, 1'h0, 16'h1234, 8'ha5},
                           '{5'h17, 8'hff, 1'h1, 16'hbeef, 8'h3c},
                           '{5'h18, 8'h5a, 1'h0, 16'h0042, 8'h81},
                           '{5'h1c, 8'h96, 1'h0, 16'h7701, 8'h0f},
                           '{5'h04, 8'h00, 1'h0, 16'h2211, 8'hc3},
                           '{5'h09, 8'h47, 1'h0, 16'h0099, 8'h66},
                           '{5'h0f, 8'hc9, 1'h1, 16'hfe10, 8'h18},
                           '{5'h06, 8'h3e, 1'h1, 16'h5533, 8'he7}};

  ext_mem_strobe DUT (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .busy(busy), .done(done), .rdata(rdata), .timing_we(timing_we),
    .timing_wdata(timing_wdata), .config_we(config_we), .config_wdata(config_wdata),
    .page_we(page_we), .page_wdata(page_wdata), .ext_mem_timing_control(tc_q),
    .ext_mem_config(cfg_q), .page_register(pg_q), .data_in(data_in), .pins(pins));
  sram_model u_mem (.pins(pins), .data_in(data_in));

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================================================
  // Phase counters sampled at the falling edge
  always @(negedge mclk) begin
    if (act) begin
      if (!pins.rd_n || !pins.wr_n) begin
        if (n_stb == 0) begin
          hi_oe_s = pins.addr_hi_oe;
          hi_s = pins.addr_hi;
          adr_s = u_mem.addr;
        end
        n_stb++;
      end else if (pins.addr_lo_oe && n_stb == 0) begin
        n_set++;
      end else if (pins.addr_lo_oe) begin
        n_hld++;
      end
      if (pins.ale) n_ale++;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic set_regs(input logic [7:0] tc, input logic [4:0] cfg);
    @(negedge mclk);
    timing_we = 1'h1;
    timing_wdata = tc;
    config_we = 1'h1;
    config_wdata = cfg;
    @(negedge mclk);
    timing_we = 1'h0;
    config_we = 1'h0;
    check("timing_rb", tc_q, tc);
    check("config_rb", cfg_q, cfg);
  endtask

  task automatic xfer(input row_t x, input logic w);
    int k;
    @(negedge mclk);
    n_stb = 0;
    n_set = 0;
    n_hld = 0;
    n_ale = 0;
    hi_oe_s = 1'h0;
    act = 1'h1;
    req = '{write: w, wide: x.wide, addr: x.addr, wdata: x.wd};
    req_valid = 1'h1;
    @(negedge mclk);
    req_valid = 1'h0;
    k = 1;
    while (done !== 1'h1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    act = 1'h0;
    n_tot = k - 1;
    if (k >= 200) begin
      check("done_wait", 1'h0, 1'h1);
      end_sim();
    end else begin
      check("idle_pins", {pins.rd_n, pins.wr_n, pins.data_oe, pins.addr_lo_oe}, 4'hc);
    end
  endtask

  initial begin
    {sys_rst, req_valid, act, timing_we, config_we, page_we} = 6'h20;
    {timing_wdata, page_wdata, config_wdata} = '0;
    req = '0;
    failures = 0;
    total_checks = 0;
    repeat (6) @(negedge mclk);
    sys_rst = 1'h0;
    @(negedge mclk);
    page_we = 1'h1;
    page_wdata = PAGE;
    @(negedge mclk);
    page_we = 1'h0;
    check("page_rb", pg_q, PAGE);
    foreach (rows[i]) begin
      r = rows[i];
      mux = !r.cfg[MUX_SELECT_BIT];
      nexp = int'(r.tc[7:6]) + int'(r.tc[5:2]) + 1 + int'(r.tc[1:0]) + FIXED_CYCLES;
      if (mux) nexp = nexp + 2 * (int'(r.cfg[1:0]) + 1);
      set_regs(r.tc, r.cfg);
      for (int w = 1; w >= 0; w--) begin
        xfer(r, w[0]);
        check("total", n_tot, nexp);
        check("strobe", n_stb, int'(r.tc[5:2]) + 1);
        check("setup", n_set, mux ? 0 : int'(r.tc[7:6]));
        check("hold", n_hld, mux ? 0 : int'(r.tc[1:0]));
        check("ale_high", n_ale, mux ? int'(r.cfg[1:0]) + 1 : 0);
        check("hi_oe", hi_oe_s, r.wide || r.cfg[3:2] == 2'h2);
        check("lo_addr", adr_s[7:0], r.addr[7:0]);
        if (hi_oe_s) check("hi_addr", hi_s, r.wide ? r.addr[15:8] : PAGE);
        if (w == 0) check("rdata", rdata, r.wd);
      end
    end
    // Reset in the middle of a long transfer
    set_regs(8'h00, 5'h14);
    set_regs(8'h3c, 5'h14);
    @(negedge mclk);
    req_valid = 1'h1;
    @(negedge mclk);
    req_valid = 1'h0;
    repeat (5) @(negedge mclk);
    sys_rst = 1'h1;
    repeat (2) @(negedge mclk);
    check("rst_pins", {pins.rd_n, pins.wr_n, pins.addr_lo_oe, busy}, 4'hc);
    check("rst_setup", tc_q[7:6], 2'h3);
    check("rst_hold", tc_q[1:0], 2'h3);
    sys_rst = 1'h0;
    // Internal-only mode makes no off-chip cycle
    xfer(rows[0], 1'h1);
    check("internal_total", n_tot, 0);
    check("internal_strobe", n_stb, 0);
    end_sim();
  end
endmodule
`default_nettype wire
